/* File: logic/iofm_pkg.sv */
package iofm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ANA1_SEL = 8'h00;
    localparam logic [7:0] ADDR_ANA2_SEL = 8'h04;
    localparam logic [7:0] ADDR_OT_THR = 8'h08;
    localparam logic [7:0] ADDR_FAN_DLY = 8'h0c;
    localparam logic [7:0] ADDR_MOT_WARN = 8'h10;
    localparam logic [7:0] ADDR_COMM_OUT = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_OUT_BASE = 8'h20;
    localparam logic [7:0] ADDR_OUT_LAST = 8'h4c;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AI_SEL = 8'h00;
    localparam logic [7:0] RST_RELAY_ONE = 8'h01;
    localparam logic [7:0] RST_RELAY_TWO = 8'h00;
    localparam logic [7:0] RST_DOUT_ONE = 8'h00;
    localparam logic [7:0] RST_DOUT_TWO = 8'h04;
    localparam logic [15:0] RST_OT_THR = 16'hffff;
    localparam logic [15:0] RST_FAN_DLY = 16'h0000;
    localparam logic [15:0] RST_MOT_WARN = 16'hffff;
    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    localparam logic [7:0] NC_OFFSET = 8'h64;
    localparam logic [7:0] IN_FUNC_MAX = 8'h21;
    localparam logic [7:0] OUT_FUNC_MAX = 8'h12;
    localparam logic [7:0] FN_MOTOR_FIRST = 8'h05;
    localparam logic [7:0] FN_MOTOR_LAST = 8'h07;
    localparam int FN_BRAKE = 1;
    localparam int FN_FAULT1 = 2;
    localparam int FN_FAULT23 = 3;
    localparam int FN_FAULT4 = 4;
    localparam int FN_MOTOR1 = 5;
    localparam int FN_DRV_OVL = 8;
    localparam int FN_MOT_OVL = 9;
    localparam int FN_OVL_PROT = 11;
    localparam int FN_OVERTORQUE = 12;
    localparam int FN_FAN = 13;
    localparam int FN_FREQ_REACHED = 14;
    localparam int FN_RUNNING = 15;
    localparam int FN_AUTO_START = 16;
    localparam int FN_COMM = 18;
    // ------------------------------------------------------------
    // thresholds and times
    // ------------------------------------------------------------
    localparam logic [9:0] AI_ON_LEVEL = 10'd700;
    localparam logic [9:0] AI_OFF_LEVEL = 10'd300;
    localparam int DRV_OVL_WARN_S = 10;
    localparam logic [15:0] DRV_OVL_WARN_MS = 16'(DRV_OVL_WARN_S * 1000);
    localparam int OT_REL_PCT = 90;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 25;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
endpackage : iofm_pkg

/* File: logic/iofm_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - an analog input with code zero is a frequency source or unused; codes 1 to 0x21 and their NC forms take the digital input functions, other codes leave it off.
// - an analog input used as logic turns on above 7.00 V, off below 3.00 V, and holds in between.
// - code 1 drives the output once the brake release condition holds.
// - code 2 follows a level-1 fault, code 3 a level-2 or level-3 fault, code 4 a level-4 fault.
// - codes 5 to 7 show the connected motor, and writing one for any motor set writes it into all three sets.
// - code 8 turns on 10 s before the drive overload protection would trip.
// - code 9 turns on when motor load exceeds the motor overload warning threshold.
// - code 11 turns on while the drive is in overload protection.
// - code 12 turns on above the overtorque threshold and off only below 90% of it.
// - code 13 turns the fan on at run start and off once the fan delay expires after stop.
// - code 16 follows the automatic start enable.
// - code 18 drives the output from the value written over communication.
module iofm_top #(
    parameter int CYC_PER_MS = iofm_pkg::CYC_PER_MS
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    input wire logic [9:0] ANALOG_IN_ONE,
    input wire logic [9:0] ANALOG_IN_TWO,
    input wire logic BRAKE_RELEASE,
    input wire logic [2:0] FAULT_LEVEL,
    input wire logic [1:0] MOTOR_ACTIVE,
    input wire logic DRV_OVL_ETA_VALID,
    input wire logic [15:0] DRV_OVL_ETA_MS,
    input wire logic [15:0] MOTOR_LOAD,
    input wire logic OVL_PROTECT,
    input wire logic [15:0] OUTPUT_TORQUE,
    input wire logic RUNNING,
    input wire logic FREQ_REACHED,
    input wire logic AUTO_START_EN,
    output logic ANALOG_IN_ONE_ACT,
    output logic ANALOG_IN_TWO_ACT,
    output logic ANALOG_IN_ONE_FREQ,
    output logic ANALOG_IN_TWO_FREQ,
    output logic RELAY_ONE,
    output logic RELAY_TWO_THREE,
    output logic DIGITAL_OUT_ONE,
    output logic DIGITAL_OUT_TWO
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [7:0] base_code(input logic [7:0] code);
        base_code = (code >= iofm_pkg::NC_OFFSET) ?
            8'(code - iofm_pkg::NC_OFFSET) : code;
    endfunction : base_code

    function automatic logic out_level(input logic [7:0] code,
        input logic [18:0] cond);
        logic [7:0] n;
        n = base_code(code);
        out_level = 1'b0;
        if (n != 8'h00 && n <= iofm_pkg::OUT_FUNC_MAX)
            out_level = cond[n[4:0]] ^ (code >= iofm_pkg::NC_OFFSET);
    endfunction : out_level

    function automatic logic in_level(input logic [7:0] code,
        input logic state);
        logic [7:0] n;
        n = base_code(code);
        in_level = 1'b0;
        if (n != 8'h00 && n <= iofm_pkg::IN_FUNC_MAX)
            in_level = state ^ (code >= iofm_pkg::NC_OFFSET);
    endfunction : in_level

    function automatic logic hyst(input logic [9:0] v, input logic q);
        if (v > iofm_pkg::AI_ON_LEVEL)
            hyst = 1'b1;
        else if (v < iofm_pkg::AI_OFF_LEVEL)
            hyst = 1'b0;
        else
            hyst = q;
    endfunction : hyst

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] analog_in1_func_sel;
    logic [7:0] analog_in2_func_sel;
    logic [15:0] overtorque_threshold;
    logic [15:0] fan_off_delay;
    logic [15:0] motor_warn_level;
    logic [3:0] comm_out;
    logic [7:0] out_sel [3][4];
    logic [1:0] wr_motor;
    logic [1:0] wr_out;
    logic out_hit;
    logic [7:0] wr_code;
    logic [7:0] wr_base;
    logic [7:0] out_off;

    assign out_hit = REG_ADDR >= iofm_pkg::ADDR_OUT_BASE &&
        REG_ADDR <= iofm_pkg::ADDR_OUT_LAST && REG_ADDR[1:0] == 2'b00;
    assign out_off = 8'(REG_ADDR - iofm_pkg::ADDR_OUT_BASE);
    assign wr_motor = out_off[5:4];
    assign wr_out = out_off[3:2];
    assign wr_code = REG_WDATA[7:0];
    assign wr_base = base_code(wr_code);

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            analog_in1_func_sel <= iofm_pkg::RST_AI_SEL;
            analog_in2_func_sel <= iofm_pkg::RST_AI_SEL;
            overtorque_threshold <= iofm_pkg::RST_OT_THR;
            fan_off_delay <= iofm_pkg::RST_FAN_DLY;
            motor_warn_level <= iofm_pkg::RST_MOT_WARN;
            comm_out <= 4'h0;
        end
        else if (REG_WR)
        begin
            unique case (REG_ADDR)
                iofm_pkg::ADDR_ANA1_SEL: analog_in1_func_sel <= wr_code;
                iofm_pkg::ADDR_ANA2_SEL: analog_in2_func_sel <= wr_code;
                iofm_pkg::ADDR_OT_THR: overtorque_threshold <= REG_WDATA;
                iofm_pkg::ADDR_FAN_DLY: fan_off_delay <= REG_WDATA;
                iofm_pkg::ADDR_MOT_WARN: motor_warn_level <= REG_WDATA;
                iofm_pkg::ADDR_COMM_OUT: comm_out <= REG_WDATA[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int m = 0; m < 3; m++)
            begin
                out_sel[m][0] <= iofm_pkg::RST_RELAY_ONE;
                out_sel[m][1] <= iofm_pkg::RST_RELAY_TWO;
                out_sel[m][2] <= iofm_pkg::RST_DOUT_ONE;
                out_sel[m][3] <= iofm_pkg::RST_DOUT_TWO;
            end
        end
        else if (REG_WR && out_hit && wr_motor != 2'd3)
        begin
            if (wr_base >= iofm_pkg::FN_MOTOR_FIRST &&
                wr_base <= iofm_pkg::FN_MOTOR_LAST)
            begin
                for (int m = 0; m < 3; m++)
                    out_sel[m][wr_out] <= wr_code;
            end
            else
                out_sel[wr_motor][wr_out] <= wr_code;
        end
    end

    // ------------------------------------------------------------
    // analog inputs
    // ------------------------------------------------------------
    logic ana1_state;
    logic ana2_state;

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ana1_state <= 1'b0;
            ana2_state <= 1'b0;
            ANALOG_IN_ONE_ACT <= 1'b0;
            ANALOG_IN_TWO_ACT <= 1'b0;
            ANALOG_IN_ONE_FREQ <= 1'b1;
            ANALOG_IN_TWO_FREQ <= 1'b1;
        end
        else
        begin
            ana1_state <= hyst(ANALOG_IN_ONE, ana1_state);
            ana2_state <= hyst(ANALOG_IN_TWO, ana2_state);
            ANALOG_IN_ONE_ACT <= in_level(analog_in1_func_sel, ana1_state);
            ANALOG_IN_TWO_ACT <= in_level(analog_in2_func_sel, ana2_state);
            ANALOG_IN_ONE_FREQ <= analog_in1_func_sel == 8'h00;
            ANALOG_IN_TWO_FREQ <= analog_in2_func_sel == 8'h00;
        end
    end

    // ------------------------------------------------------------
    // overtorque and fan
    // ------------------------------------------------------------
    logic overtorque;
    logic fan_on;
    logic [15:0] fan_ms;
    logic [31:0] ms_div;
    logic ms_tick;
    logic [23:0] torque_pct;
    logic [23:0] release_pct;

    assign torque_pct = 24'(OUTPUT_TORQUE) * 24'd100;
    assign release_pct = 24'(overtorque_threshold) *
        24'(iofm_pkg::OT_REL_PCT);
    assign ms_tick = ms_div == 32'(CYC_PER_MS - 1);

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            overtorque <= 1'b0;
        else if (OUTPUT_TORQUE > overtorque_threshold)
            overtorque <= 1'b1;
        else if (torque_pct < release_pct)
            overtorque <= 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            ms_div <= 32'h0;
        else if (RUNNING || ms_tick)
            ms_div <= 32'h0;
        else
            ms_div <= ms_div + 32'h1;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fan_on <= 1'b0;
            fan_ms <= 16'h0;
        end
        else if (RUNNING)
        begin
            fan_on <= 1'b1;
            fan_ms <= 16'h0;
        end
        else if (fan_on)
        begin
            if (fan_ms >= fan_off_delay)
                fan_on <= 1'b0;
            else if (ms_tick)
                fan_ms <= fan_ms + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // output routing
    // ------------------------------------------------------------
    logic [18:0] cond;
    logic [3:0] outs;

    always_comb
    begin
        cond = 19'h0;
        cond[iofm_pkg::FN_BRAKE] = BRAKE_RELEASE;
        cond[iofm_pkg::FN_FAULT1] = FAULT_LEVEL == 3'd1;
        cond[iofm_pkg::FN_FAULT23] = FAULT_LEVEL == 3'd2 ||
            FAULT_LEVEL == 3'd3;
        cond[iofm_pkg::FN_FAULT4] = FAULT_LEVEL == 3'd4;
        for (int m = 0; m < 3; m++)
            cond[iofm_pkg::FN_MOTOR1 + m] = MOTOR_ACTIVE == 2'(m);
        cond[iofm_pkg::FN_DRV_OVL] = DRV_OVL_ETA_VALID &&
            DRV_OVL_ETA_MS <= iofm_pkg::DRV_OVL_WARN_MS;
        cond[iofm_pkg::FN_MOT_OVL] = MOTOR_LOAD > motor_warn_level;
        cond[iofm_pkg::FN_OVL_PROT] = OVL_PROTECT;
        cond[iofm_pkg::FN_OVERTORQUE] = overtorque;
        cond[iofm_pkg::FN_FAN] = fan_on;
        cond[iofm_pkg::FN_FREQ_REACHED] = FREQ_REACHED;
        cond[iofm_pkg::FN_RUNNING] = RUNNING;
        cond[iofm_pkg::FN_AUTO_START] = AUTO_START_EN;
    end

    always_comb
    begin
        logic [1:0] mi;
        logic [18:0] c;
        mi = (MOTOR_ACTIVE == 2'd3) ? 2'd0 : MOTOR_ACTIVE;
        c = 19'h0;
        for (int o = 0; o < 4; o++)
        begin
            c = cond;
            c[iofm_pkg::FN_COMM] = comm_out[o];
            outs[o] = out_level(out_sel[mi][o], c);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RELAY_ONE <= 1'b0;
            RELAY_TWO_THREE <= 1'b0;
            DIGITAL_OUT_ONE <= 1'b0;
            DIGITAL_OUT_TWO <= 1'b0;
        end
        else
        begin
            RELAY_ONE <= outs[0];
            RELAY_TWO_THREE <= outs[1];
            DIGITAL_OUT_ONE <= outs[2];
            DIGITAL_OUT_TWO <= outs[3];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb
    begin
        rd_mux = 16'h0;
        unique case (REG_ADDR)
            iofm_pkg::ADDR_ANA1_SEL: rd_mux = {8'h00, analog_in1_func_sel};
            iofm_pkg::ADDR_ANA2_SEL: rd_mux = {8'h00, analog_in2_func_sel};
            iofm_pkg::ADDR_OT_THR: rd_mux = overtorque_threshold;
            iofm_pkg::ADDR_FAN_DLY: rd_mux = fan_off_delay;
            iofm_pkg::ADDR_MOT_WARN: rd_mux = motor_warn_level;
            iofm_pkg::ADDR_COMM_OUT: rd_mux = {12'h000, comm_out};
            iofm_pkg::ADDR_STATUS: rd_mux = {6'h00, overtorque, fan_on,
                ana2_state, ana1_state, ANALOG_IN_TWO_ACT, ANALOG_IN_ONE_ACT,
                DIGITAL_OUT_TWO, DIGITAL_OUT_ONE, RELAY_TWO_THREE,
                RELAY_ONE};
            default:
                if (out_hit && wr_motor != 2'd3)
                    rd_mux = {8'h00, out_sel[wr_motor][wr_out]};
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            REG_RDATA <= 16'h0;
        else if (REG_RD)
            REG_RDATA <= rd_mux;
        else
            REG_RDATA <= 16'h0;
    end

endmodule : iofm_top

/* File: tb/iofm_load_model.sv */
`timescale 1ns/1ps
// relay coils on the drive side, contacts on the field side
module iofm_load_model #(
    parameter bit SLOW = 1'b1
) (
    input wire logic clk,
    input wire logic [3:0] coil,
    output logic [3:0] contact
);
    logic [3:0] arm;
    always_ff @(posedge clk)
    begin
        arm <= coil;
        contact <= SLOW ? arm : coil;
    end
endmodule : iofm_load_model

/* File: tb/iofm_properties.sv */
`timescale 1ns/1ps
module iofm_properties #(
    parameter int CYC_PER_MS = iofm_pkg::CYC_PER_MS
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic [9:0] ANALOG_IN_ONE,
    input wire logic BRAKE_RELEASE,
    input wire logic [2:0] FAULT_LEVEL,
    input wire logic [1:0] MOTOR_ACTIVE,
    input wire logic ANALOG_IN_ONE_ACT,
    input wire logic ANALOG_IN_ONE_FREQ,
    input wire logic RELAY_ONE
);
    // ----
    // shadow of written codes
    // ----
    logic [7:0] code_ana1;
    logic [7:0] c0;
    logic [7:0] c0m;
    logic [7:0] base;
    logic comm0;
    logic hit;
    assign base = REG_WDATA[7:0] - (REG_WDATA[7:0] >= iofm_pkg::NC_OFFSET ?
        iofm_pkg::NC_OFFSET : 8'h00);
    assign hit = REG_ADDR == iofm_pkg::ADDR_OUT_BASE ||
        ((REG_ADDR == 8'h30 || REG_ADDR == 8'h40) &&
        base >= iofm_pkg::FN_MOTOR_FIRST && base <= iofm_pkg::FN_MOTOR_LAST);
    assign c0m = MOTOR_ACTIVE == 2'h0 ? c0 : 8'hff;
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            code_ana1 <= iofm_pkg::RST_AI_SEL;
            c0 <= iofm_pkg::RST_RELAY_ONE;
            comm0 <= 1'b0;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == iofm_pkg::ADDR_ANA1_SEL)
                code_ana1 <= REG_WDATA[7:0];
            if (hit)
                c0 <= REG_WDATA[7:0];
            if (REG_ADDR == iofm_pkg::ADDR_COMM_OUT)
                comm0 <= REG_WDATA[0];
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    property p_rd_idle;
        !REG_RD |=> REG_RDATA == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_freq;
        ANALOG_IN_ONE_FREQ == ($past(code_ana1) == 8'h00);
    endproperty
    a_freq: assert property (p_freq) else $error("freq flag");
    property p_ai_on;
        (ANALOG_IN_ONE > iofm_pkg::AI_ON_LEVEL && code_ana1 == 8'h01) [*3]
            |-> ANALOG_IN_ONE_ACT;
    endproperty
    a_ai_on: assert property (p_ai_on) else $error("ai on");
    property p_brake;
        c0m == 8'h01 |=> RELAY_ONE == $past(BRAKE_RELEASE);
    endproperty
    a_brake: assert property (p_brake) else $error("brake");
    property p_fault;
        c0m == 8'h03 |=> RELAY_ONE == ($past(FAULT_LEVEL) inside {3'h2, 3'h3});
    endproperty
    a_fault: assert property (p_fault) else $error("fault");
    property p_motor;
        c0 == 8'h06 |=> RELAY_ONE == ($past(MOTOR_ACTIVE) == 2'h1);
    endproperty
    a_motor: assert property (p_motor) else $error("motor");
    property p_comm;
        c0m == 8'h12 |=> RELAY_ONE == $past(comm0);
    endproperty
    a_comm: assert property (p_comm) else $error("comm");
    property p_nc;
        c0m == 8'h65 |=> RELAY_ONE != $past(BRAKE_RELEASE);
    endproperty
    a_nc: assert property (p_nc) else $error("nc polarity");
    c_read: cover property (REG_RD ##1 REG_RDATA != 16'h0000);
    c_relay: cover property ($rose(RELAY_ONE));
    c_ai: cover property ($fell(ANALOG_IN_ONE_ACT));
endmodule : iofm_properties
bind iofm_top iofm_properties #(.CYC_PER_MS(CYC_PER_MS)) u_props (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .ANALOG_IN_ONE(ANALOG_IN_ONE),
    .BRAKE_RELEASE(BRAKE_RELEASE), .FAULT_LEVEL(FAULT_LEVEL),
    .MOTOR_ACTIVE(MOTOR_ACTIVE), .RELAY_ONE(RELAY_ONE),
    .ANALOG_IN_ONE_ACT(ANALOG_IN_ONE_ACT),
    .ANALOG_IN_ONE_FREQ(ANALOG_IN_ONE_FREQ)
);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] a1 = 10'h000;
    logic [9:0] a2 = 10'h000;
    logic brk = 1'b0;
    logic [2:0] flt = 3'h0;
    logic [1:0] mot = 2'h0;
    logic etv = 1'b0;
    logic [15:0] eta = 16'h0000;
    logic [15:0] ld = 16'h0000;
    logic ovl = 1'b0;
    logic [15:0] trq = 16'h0000;
    logic run = 1'b0;
    logic aut = 1'b0;
    logic [9:0] lv [6] = '{10'h2bd, 10'h1f4, 10'h12b, 10'h1f4, 10'h2bc, 10'h2bd};
    logic [5:0] ex = 6'h23;
    wire [15:0] rdat;
    wire [3:0] ai;
    wire [3:0] outs;
    wire [3:0] cont;
    wire [7:0] all = {ai, outs};
    int bad_count = 0;
    int comparisons = 0;
    int i;
    int j;
    always #12.5 clk = ~clk;
    iofm_top #(.CYC_PER_MS(4)) dut (
        .CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(adr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .ANALOG_IN_ONE(a1),
        .ANALOG_IN_TWO(a2), .BRAKE_RELEASE(brk), .FAULT_LEVEL(flt),
        .MOTOR_ACTIVE(mot), .DRV_OVL_ETA_VALID(etv), .DRV_OVL_ETA_MS(eta),
        .MOTOR_LOAD(ld), .OVL_PROTECT(ovl), .OUTPUT_TORQUE(trq),
        .RUNNING(run), .FREQ_REACHED(1'b0), .AUTO_START_EN(aut),
        .ANALOG_IN_ONE_ACT(ai[0]), .ANALOG_IN_TWO_ACT(ai[1]),
        .ANALOG_IN_ONE_FREQ(ai[2]), .ANALOG_IN_TWO_FREQ(ai[3]),
        .RELAY_ONE(outs[0]), .RELAY_TWO_THREE(outs[1]),
        .DIGITAL_OUT_ONE(outs[2]), .DIGITAL_OUT_TWO(outs[3])
    );
    iofm_load_model field (.clk(clk), .coil(outs), .contact(cont));
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, rdat);
    endtask : rd_chk
    task automatic set_out(input int k, input logic [7:0] c);
        wr_reg(iofm_pkg::ADDR_OUT_BASE + 8'(k * 4), {8'h00, c});
    endtask : set_out
    // samples an output three edges on, returns on a rising edge
    task automatic look(input int k, input logic e);
        repeat (3) @(posedge clk);
        #1;
        chk($sformatf("pin %0d", k), {15'h0000, e}, {15'h0000, all[k]});
        @(posedge clk);
    endtask : look
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(iofm_pkg::ADDR_OUT_BASE, {8'h00, iofm_pkg::RST_RELAY_ONE});
        rd_chk(iofm_pkg::ADDR_OUT_LAST, {8'h00, iofm_pkg::RST_DOUT_TWO});
        rd_chk(iofm_pkg::ADDR_OT_THR, iofm_pkg::RST_OT_THR);
        wr_reg(8'h60, 16'h1234);
        rd_chk(8'h60, 16'h0000);
        $display("test regs done");
        look(6, 1'b1);
        wr_reg(iofm_pkg::ADDR_ANA1_SEL, 16'h0001);
        look(6, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            a1 <= lv[i];
            look(4, ex[i]);
        end
        wr_reg(iofm_pkg::ADDR_ANA1_SEL, 16'h0065);
        look(4, 1'b0);
        wr_reg(iofm_pkg::ADDR_ANA2_SEL, 16'h0002);
        a2 <= 10'h2bd;
        look(5, 1'b1);
        look(7, 1'b0);
        rd_chk(iofm_pkg::ADDR_STATUS, 16'h00e0);
        $display("test analog done");
        brk <= 1'b1;
        look(0, 1'b1);
        brk <= 1'b0;
        look(0, 1'b0);
        set_out(0, 8'h65);
        look(0, 1'b1);
        set_out(0, 8'h64);
        look(0, 1'b0);
        for (i = 2; i < 5; i++)
        begin
            set_out(0, 8'(i));
            for (j = 0; j < 5; j++)
            begin
                flt <= 3'(j);
                look(0, (i == 2 && j == 1) || (i == 4 && j == 4) ||
                    (i == 3 && (j == 2 || j == 3)));
            end
        end
        wr_reg(iofm_pkg::ADDR_OUT_BASE + 8'h20, 16'h0006);
        for (i = 0; i < 4; i++)
        begin
            mot <= 2'(i % 3);
            look(0, i == 1);
        end
        rd_chk(iofm_pkg::ADDR_OUT_BASE + 8'h10, 16'h0006);
        $display("test relay one done");
        set_out(3, 8'h08);
        etv <= 1'b1;
        eta <= 16'h2710;
        look(3, 1'b1);
        eta <= 16'h2711;
        look(3, 1'b0);
        wr_reg(iofm_pkg::ADDR_MOT_WARN, 16'h0100);
        set_out(2, 8'h09);
        ld <= 16'h0101;
        look(2, 1'b1);
        ld <= 16'h0100;
        look(2, 1'b0);
        set_out(1, 8'h0b);
        ovl <= 1'b1;
        look(1, 1'b1);
        ovl <= 1'b0;
        look(1, 1'b0);
        wr_reg(iofm_pkg::ADDR_OT_THR, 16'h03e8);
        set_out(1, 8'h0c);
        trq <= 16'h03e9;
        look(1, 1'b1);
        trq <= 16'h0384;
        look(1, 1'b1);
        trq <= 16'h0383;
        look(1, 1'b0);
        wr_reg(iofm_pkg::ADDR_FAN_DLY, 16'h0002);
        set_out(2, 8'h0d);
        run <= 1'b1;
        look(2, 1'b1);
        run <= 1'b0;
        look(2, 1'b1);
        repeat (20) @(posedge clk);
        look(2, 1'b0);
        set_out(0, 8'h10);
        aut <= 1'b1;
        look(0, 1'b1);
        aut <= 1'b0;
        look(0, 1'b0);
        set_out(0, 8'h12);
        wr_reg(iofm_pkg::ADDR_COMM_OUT, 16'h0001);
        look(0, 1'b1);
        #1;
        chk("contacts", 16'h0001, {12'h000, cont});
        wr_reg(iofm_pkg::ADDR_COMM_OUT, 16'h0000);
        look(0, 1'b0);
        $display("test outputs done");
        end_sim();
    end
endmodule : testbench
